// file: silo_pkg.sv
package silo_pkg;
  localparam int STAGES = 8;
  localparam logic [7:0] RESET_VAL = 8'h00;
  localparam int SYNC_DEPTH = 2;
  localparam int FIRST_STAGE = 0;
  localparam int LAST_STAGE = 7;
  // Order {data, clear_n, shift clk, latch clk, enable_n}: clear and enable idle high
  localparam logic [4:0] SYNC_RESET_VAL = 5'h09;
endpackage : silo_pkg

// file: silo_sync_if.sv
`timescale 1ns/1ns
interface silo_sync_if;
  logic [4:0] raw;
  logic [4:0] sync;
  modport src (output raw, input sync);
  modport dst (input raw, output sync);
endinterface : silo_sync_if

// file: silo_sync.sv
`timescale 1ns/1ns
module silo_sync (
  input wire logic i_core_clk,
  input wire logic i_resetn,
  silo_sync_if.dst bus
);
  logic [4:0] meta_q;
  logic [4:0] sync_q;

  // Two-stage synchroniser per pin
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      meta_q <= silo_pkg::SYNC_RESET_VAL;
      sync_q <= silo_pkg::SYNC_RESET_VAL;
    end else begin
      meta_q <= bus.raw;
      sync_q <= meta_q;
    end
  end

  assign bus.sync = sync_q;
endmodule : silo_sync

// file: silo_top.sv
// Overview of operation
// - Clear low forces all shift stages zero
// - Shift clock rise shifts, loads serial input
// - High and low serial levels both captured
// - Shift clock fall leaves contents unchanged
// - Latch clock rise copies all stages
// - Latch clock fall keeps latch unchanged
// - Enable low drives outputs from latch
// - Enable high three-states outputs, state kept
`timescale 1ns/1ns
module silo_top (
  input wire logic i_core_clk,
  input wire logic i_resetn,
  input wire logic i_data_shift_in,
  input wire logic i_shift_clear_n,
  input wire logic i_shift_clock,
  input wire logic i_latch_load_clock,
  input wire logic i_output_enable_n,
  output logic [7:0] o_latch_outputs,
  output logic [7:0] o_latch_outputs_oe_n,
  output logic o_cascade_out
);
  silo_sync_if sif ();
  logic data_s, clr_n_s, sck_s, lck_s, oe_n_s;
  logic sck_prev_q, lck_prev_q;
  logic [7:0] shift_q, shift_d;
  logic [7:0] latch_q;
  logic [7:0] out_q;
  logic [7:0] oe_n_q;
  logic sck_rise, lck_rise;
  logic [7:0] shift_in;

  assign sif.raw = {i_data_shift_in, i_shift_clear_n, i_shift_clock,
                    i_latch_load_clock, i_output_enable_n};

  silo_sync u_sync (
    .i_core_clk(i_core_clk),
    .i_resetn(i_resetn),
    .bus(sif)
  );

  assign {data_s, clr_n_s, sck_s, lck_s, oe_n_s} = sif.sync;

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      sck_prev_q <= 1'h0;
      lck_prev_q <= 1'h0;
    end else begin
      sck_prev_q <= sck_s;
      lck_prev_q <= lck_s;
    end
  end

  // Rising edge of a synchronised pin against its previous level
  function automatic logic is_rise(input logic now_lvl, input logic prev_lvl);
    return now_lvl & ~prev_lvl;
  endfunction : is_rise

  // Only rising edges act; falling edges ignored
  assign sck_rise = is_rise(sck_s, sck_prev_q);
  assign lck_rise = is_rise(lck_s, lck_prev_q);

  // Stage zero takes the serial level, every later stage its neighbour
  assign shift_in[silo_pkg::FIRST_STAGE] = data_s;
  for (genvar g = silo_pkg::FIRST_STAGE + 1; g <= silo_pkg::LAST_STAGE; g++) begin : g_chain
    assign shift_in[g] = shift_q[g-1];
  end

  always_comb begin
    shift_d = shift_q;
    if (!clr_n_s) begin
      shift_d = silo_pkg::RESET_VAL;
    end else if (sck_rise) begin
      shift_d = shift_in;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      shift_q <= silo_pkg::RESET_VAL;
    end else begin
      shift_q <= shift_d;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      latch_q <= silo_pkg::RESET_VAL;
    end else if (lck_rise) begin
      latch_q <= shift_q;
    end
  end

  // Output drivers: enable low drives, high floats
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      out_q <= silo_pkg::RESET_VAL;
      oe_n_q <= 8'hFF;
    end else begin
      out_q <= latch_q;
      oe_n_q <= {silo_pkg::STAGES{oe_n_s}};
    end
  end

  assign o_latch_outputs = out_q;
  assign o_latch_outputs_oe_n = oe_n_q;
  assign o_cascade_out = shift_q[silo_pkg::LAST_STAGE];

  AST_CLEAR_ZERO: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    !clr_n_s |=> shift_q == 8'h00) else $error("shift not cleared");
  AST_SHIFT_RISE: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    clr_n_s && sck_rise |=> shift_q[7:1] == $past(shift_q[6:0]))
    else $error("shift stages did not advance");
  AST_SERIAL_CAPTURE: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    clr_n_s && sck_rise |=> shift_q[0] == $past(data_s))
    else $error("serial level not captured");
  AST_NO_FALL_SHIFT: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    clr_n_s && !sck_rise |=> $stable(shift_q)) else $error("shift without rising edge");
  AST_LATCH_LOAD: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    lck_rise |=> latch_q == $past(shift_q)) else $error("latch not loaded");
  AST_LATCH_HOLD: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    !lck_rise |=> $stable(latch_q)) else $error("latch changed without rise");
  AST_OUT_DRIVE: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    !oe_n_s |=> o_latch_outputs_oe_n == 8'h00
      && o_latch_outputs == $past(latch_q)) else $error("outputs not driven");
  AST_OUT_FLOAT: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    oe_n_s |=> o_latch_outputs_oe_n == 8'hFF) else $error("outputs not floating");
  AST_CASCADE: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    clr_n_s && sck_rise |=> o_cascade_out == $past(shift_q[6]))
    else $error("cascade output wrong");

  // Clear dominates the shift clock; a latch rise still copies the shift stages
  AST_CLEAR_OVER_SHIFT: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    !clr_n_s && sck_rise
      |=> shift_q == 8'h00)
    else $error("shift rise beat clear");
  AST_CLEAR_OVER_LATCH: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    !clr_n_s && lck_rise
      |=> shift_q == 8'h00)
    else $error("latch rise disturbed clear");
  AST_CLEAR_CASCADE: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    !clr_n_s
      |=> !o_cascade_out)
    else $error("cascade not cleared");
  AST_CLEAR_PIN: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    $fell(i_shift_clear_n)
      |-> ##3 shift_q == 8'h00)
    else $error("clear pin too slow");

  // Shift clock: one step per rise, none on fall
  AST_SHIFT_SYNC: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    $rose(i_shift_clock)
      |-> ##2 sck_rise)
    else $error("shift rise not seen");
  AST_SHIFT_ONE_STEP: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    sck_rise
      |=> !sck_rise)
    else $error("shift rise repeated");
  AST_HIGH_CAPTURE: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    clr_n_s && sck_rise && data_s
      |=> shift_q[silo_pkg::FIRST_STAGE])
    else $error("high level lost");
  AST_LOW_CAPTURE: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    clr_n_s && sck_rise && !data_s
      |=> !shift_q[silo_pkg::FIRST_STAGE])
    else $error("low level lost");
  AST_FALL_NO_SHIFT: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    clr_n_s && $fell(sck_s)
      |=> $stable(shift_q))
    else $error("shift on falling edge");
  AST_PIN_FALL_IGNORED: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    $fell(i_shift_clock)
      |-> ##2 !sck_rise)
    else $error("falling pin seen as rise");

  // Latch clock: copy on rise, hold on fall
  AST_LATCH_SYNC: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    $rose(i_latch_load_clock)
      |-> ##2 lck_rise)
    else $error("latch rise not seen");
  AST_LATCH_ONE_COPY: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    lck_rise
      |=> !lck_rise)
    else $error("latch rise repeated");
  AST_LATCH_FALL_HOLD: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    $fell(lck_s)
      |=> $stable(latch_q))
    else $error("latch changed on fall");
  AST_LATCH_PIN_FALL: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    $fell(i_latch_load_clock)
      |-> ##2 !lck_rise)
    else $error("falling latch pin seen as rise");

  // Output enable: drive or float, state kept
  AST_OUT_FOLLOWS: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    lck_rise
      |=> ##1 o_latch_outputs == $past(shift_q, 2))
    else $error("outputs miss latched data");
  AST_OE_PIN_DRIVE: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    $fell(i_output_enable_n)
      |-> ##3 o_latch_outputs_oe_n == 8'h00)
    else $error("enable pin did not drive");
  AST_OE_PIN_FLOAT: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    $rose(i_output_enable_n)
      |-> ##3 o_latch_outputs_oe_n == 8'hFF)
    else $error("enable pin did not float");
  AST_FLOAT_KEEPS_LATCH: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    oe_n_s && !lck_rise
      |=> $stable(latch_q))
    else $error("latch changed while floating");
  AST_FLOAT_KEEPS_SHIFT: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    oe_n_s && clr_n_s && !sck_rise
      |=> $stable(shift_q))
    else $error("shift changed while floating");
  AST_FLOAT_DATA_KEPT: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    oe_n_s
      |=> o_latch_outputs == $past(latch_q))
    else $error("data lost while floating");

  // Cascade moves only with the chain
  AST_CASCADE_HOLD: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    clr_n_s && !sck_rise
      |=> $stable(o_cascade_out))
    else $error("cascade changed without shift");

  COV_SHIFT: cover property (@(posedge i_core_clk) disable iff (!i_resetn)
    clr_n_s && sck_rise && data_s);
  COV_LATCH: cover property (@(posedge i_core_clk) disable iff (!i_resetn) lck_rise);
  COV_CLEAR: cover property (@(posedge i_core_clk) disable iff (!i_resetn)
    !clr_n_s && sck_rise);
  COV_FLOAT: cover property (@(posedge i_core_clk) disable iff (!i_resetn)
    oe_n_s && lck_rise);
  COV_DRIVE: cover property (@(posedge i_core_clk) disable iff (!i_resetn)
    !oe_n_s && lck_rise);
endmodule : silo_top

// file: silo_host_model.sv
`timescale 1ns/1ns
module silo_host_model (
  input wire logic i_core_clk,
  output logic o_data,
  output logic o_clear_n,
  output logic o_shift_clk,
  output logic o_latch_clk,
  output logic o_oe_n
);
  // Idle levels: clocks low, clear and enable inactive
  initial begin
    o_data <= 1'b0;
    o_clear_n <= 1'b1;
    o_shift_clk <= 1'b0;
    o_latch_clk <= 1'b0;
    o_oe_n <= 1'b1;
  end
  task automatic hold();
    repeat (4) @(posedge i_core_clk);
  endtask : hold
  task automatic shift_bit(input logic b);
    o_data <= b;
    hold();
    o_shift_clk <= 1'b1;
    hold();
    o_shift_clk <= 1'b0;
    // Data line no longer valid after the pulse
    o_data <= ~b;
    hold();
  endtask : shift_bit
  task automatic latch();
    o_latch_clk <= 1'b1;
    hold();
    o_latch_clk <= 1'b0;
    hold();
  endtask : latch
  task automatic set_oe(input logic v);
    o_oe_n <= v;
    hold();
  endtask : set_oe
  task automatic set_clear(input logic v);
    o_clear_n <= v;
    hold();
  endtask : set_clear
endmodule : silo_host_model

// file: silo_top_tb.sv
`timescale 1ns/1ns
module silo_top_tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic data_shift_in, clr_n, sck, lck, oe_n, casc;
  logic [7:0] q, q_oe_n;
  int fail_count = 0;
  int tests_run = 0;
  initial begin
    forever #10 clk = ~clk;
  end
  silo_host_model i_host (.i_core_clk(clk), .o_data(data_shift_in), .o_clear_n(clr_n),
    .o_shift_clk(sck), .o_latch_clk(lck), .o_oe_n(oe_n));
  silo_top i_dut (.i_core_clk(clk), .i_resetn(rst_n), .i_data_shift_in(data_shift_in),
    .i_shift_clear_n(clr_n), .i_shift_clock(sck), .i_latch_load_clock(lck),
    .i_output_enable_n(oe_n), .o_latch_outputs(q), .o_latch_outputs_oe_n(q_oe_n),
    .o_cascade_out(casc));
  task automatic check(input string n, input logic [7:0] s, input logic [7:0] e);
    #1;
    tests_run++;
    if (s !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
    // Back on the edge so the next stimulus starts there
    @(posedge clk);
  endtask : check
  task automatic conclude();
    $display("Checks %0d errors %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : conclude
  task automatic t_shift_latch();
    logic [7:0] pattern = 8'hA5;
    for (int i = 7; i >= 0; i--) i_host.shift_bit(pattern[i]);
    check("cascade", {7'h00, casc}, 8'h01);
    i_host.latch();
    i_host.set_oe(1'b0);
    check("outputs", q, 8'hA5);
    check("enables", q_oe_n, 8'h00);
  endtask : t_shift_latch
  task automatic t_tristate();
    i_host.shift_bit(1'b0);
    check("held", q, 8'hA5);
    check("cascade", {7'h00, casc}, 8'h00);
    i_host.set_oe(1'b1);
    check("float", q_oe_n, 8'hFF);
    i_host.latch();
    i_host.set_oe(1'b0);
    check("shifted", q, 8'h4A);
  endtask : t_tristate
  task automatic t_clear();
    i_host.set_clear(1'b0);
    i_host.shift_bit(1'b1);
    i_host.latch();
    i_host.set_clear(1'b1);
    check("cleared", q, 8'h00);
    i_host.shift_bit(1'b1);
    i_host.latch();
    check("high bit", q, 8'h01);
  endtask : t_clear
  task automatic t_reset();
    rst_n <= 1'b0;
    @(posedge clk);
    check("reset data", q, 8'h00);
    check("reset enables", q_oe_n, 8'hFF);
    check("reset cascade", {7'h00, casc}, 8'h00);
    rst_n <= 1'b1;
    i_host.hold();
    check("resume enables", q_oe_n, 8'h00);
  endtask : t_reset
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    t_shift_latch();
    t_tristate();
    t_clear();
    t_reset();
    conclude();
  end
  initial begin
    repeat (5000) @(posedge clk);
    fail_count++;
    conclude();
  end
endmodule : silo_top_tb
